// *** hdl/asps_pkg.sv ***
package asps_pkg;

    // Clock and time base.
    localparam int CLK_HZ = 100_000_000;
    localparam int XTAL_HZ = 10_000_000;
    localparam int TBASE_DIV = 2;
    localparam int TBASE_HZ = XTAL_HZ / TBASE_DIV;
    localparam int TBASE_CYC = CLK_HZ / TBASE_HZ;
    localparam logic [4:0] TBASE_LAST = 5'(TBASE_CYC - 1);

    // Rate limits expressed as time-base divisors.
    localparam int PACER_MAX_HZ = 333_000;
    localparam int PACER_MIN_DIV = (TBASE_HZ + PACER_MAX_HZ - 1)
        / PACER_MAX_HZ;
    localparam int BURST_MIN_HZ_X10 = 39216;
    localparam int BURST_MAX_DIV = (TBASE_HZ * 10) / BURST_MIN_HZ_X10;
    localparam logic [31:0] PACER_DIV_MIN = 32'(PACER_MIN_DIV);
    localparam logic [31:0] BURST_DIV_MIN = 32'(PACER_MIN_DIV);
    localparam logic [31:0] BURST_DIV_MAX = 32'(BURST_MAX_DIV);

    // Queue geometry.
    localparam int QDEPTH = 64;
    localparam int QAW = 6;
    localparam int CHW = 6;
    localparam int GNW = 2;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PACER_DIV = 8'h04;
    localparam logic [7:0] OFS_BURST_DIV = 8'h08;
    localparam logic [7:0] OFS_QLEN = 8'h0C;
    localparam logic [7:0] OFS_CMD = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_RESULT = 8'h18;
    localparam logic [7:0] OFS_QBASE = 8'h80;

    // Control fields.
    localparam int CTRL_BURST = 0;
    localparam int CTRL_SRC_LO = 1;
    localparam int CTRL_FALL = 3;
    localparam int CTRL_RUN = 4;
    // Command bits.
    localparam int CMD_CONVERT = 0;
    // Status fields.
    localparam int ST_DONE = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_PTR_LO = 8;

    localparam logic [31:0] PACER_DIV_RST = 32'h0000_1388;
    localparam logic [31:0] BURST_DIV_RST = 32'h0000_0010;
    localparam logic [6:0] QLEN_RST = 7'h01;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam int ADC_W = 16;

    typedef enum logic [1:0] {
        ASPS_SRC_SOFT = 2'h0,
        ASPS_SRC_INT = 2'h1,
        ASPS_SRC_EXT = 2'h2
    } asps_src_t;

    typedef enum logic [1:0] {
        ASPS_IDLE = 2'b00,
        ASPS_BURST = 2'b01
    } asps_state_t;

    typedef struct packed {
        logic [CHW-1:0] chan;
        logic [GNW-1:0] gain;
    } asps_entry_t;

    // Packed from the top down, so run sits on bit 4 and burst on bit 0,
    // matching the control field positions above.
    typedef struct packed {
        logic run;
        logic fall;
        asps_src_t src;
        logic burst;
    } asps_ctrl_t;

endpackage

// *** hdl/asps_seq.sv ***
`timescale 1ns/100ps
`default_nettype none
module asps_seq (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // External pacer pin.
    input wire logic ext_pacer_clock_in,
    // Converter side.
    output logic conv_start,
    output asps_pkg::asps_entry_t conv_entry,
    input wire logic conv_done,
    input wire logic [asps_pkg::ADC_W-1:0] conv_data,
    // Shared internal pacer tick for other paced events.
    output logic pacer_tick
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and state.
    asps_pkg::asps_ctrl_t ctrl;
    logic [31:0] pacer_div;
    logic [31:0] burst_div;
    logic [6:0] qlen;
    asps_pkg::asps_entry_t queue [asps_pkg::QDEPTH];
    logic [asps_pkg::QAW-1:0] qptr;
    logic done_flag;
    logic [asps_pkg::ADC_W-1:0] result;
    asps_pkg::asps_state_t state;
    logic [4:0] tb_cnt;
    logic tb_tick;
    logic [31:0] pacer_cnt;
    logic [31:0] burst_cnt;
    logic int_pulse;
    logic burst_pulse;
    logic ext_q;
    logic ext_edge;
    logic sw_cmd;
    logic pace_pulse;
    logic entry_go;
    logic last_entry;
    logic ap_wr;
    logic [8:0] ap_addr;
    logic ap_valid;

    // Clamps a programmed divisor into its legal range.
    function automatic logic [31:0] clamp_div(input logic [31:0] v,
                                              input logic [31:0] lo,
                                              input logic [31:0] hi);
        clamp_div = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // True when a byte address falls inside the queue window.
    // The window holds all 64 words, so it needs a ninth address bit.
    function automatic logic q_hit(input logic [8:0] a);
        q_hit = (a >= 9'(asps_pkg::OFS_QBASE))
            && (a < 9'(asps_pkg::OFS_QBASE) + 9'(asps_pkg::QDEPTH * 4));
    endfunction

    // True for the register space below the queue window.
    function automatic logic reg_hit(input logic [8:0] a);
        reg_hit = a < 9'(asps_pkg::OFS_QBASE);
    endfunction

    // Queue index of a byte address inside the window; the first word of
    // the window is entry 0, the one the scan pointer starts from.
    function automatic logic [asps_pkg::QAW-1:0] q_idx(input logic [8:0] a);
        logic [6:0] w;
        w = a[8:2] - 7'(asps_pkg::OFS_QBASE >> 2);
        q_idx = w[asps_pkg::QAW-1:0];
    endfunction

    // True on the last time-base tick of a divided period.
    // Pacer and burst clock share it, so both count periods alike.
    function automatic logic div_end(input logic [31:0] cnt,
                                     input logic [31:0] div);
        div_end = cnt >= div - 32'h0000_0001;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus address phase capture; the slave never waits.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ap_valid <= 1'b0;
            ap_wr <= 1'b0;
            ap_addr <= 9'h000;
        end else if (hready) begin
            ap_valid <= hsel && (htrans == asps_pkg::HTRANS_NONSEQ
                || htrans == asps_pkg::HTRANS_SEQ);
            ap_wr <= hwrite;
            ap_addr <= haddr[8:0];
        end
    end

    // Always OKAY; ready in every cycle after reset, not during it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Configuration writes; reset picks paced mode.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= '0;
            pacer_div <= asps_pkg::PACER_DIV_RST;
            burst_div <= asps_pkg::BURST_DIV_RST;
            qlen <= asps_pkg::QLEN_RST;
        end else if (ap_valid && ap_wr && reg_hit(ap_addr)) begin
            // Queue words never alias a register, whatever the low bits.
            unique case (ap_addr[7:0])
                asps_pkg::OFS_CTRL: begin
                    ctrl <= hwdata[asps_pkg::CTRL_RUN:asps_pkg::CTRL_BURST];
                end
                asps_pkg::OFS_PACER_DIV: begin
                    pacer_div <= clamp_div(hwdata, asps_pkg::PACER_DIV_MIN,
                        32'hFFFF_FFFF);
                end
                asps_pkg::OFS_BURST_DIV: begin
                    burst_div <= clamp_div(hwdata, asps_pkg::BURST_DIV_MIN,
                        asps_pkg::BURST_DIV_MAX);
                end
                asps_pkg::OFS_QLEN: begin
                    qlen <= (hwdata[6:0] == 7'h00 || hwdata[6:0] > 7'h40)
                        ? 7'h40 : hwdata[6:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Queue storage, one word per entry above the base offset.
    always_ff @(posedge clk) begin
        if (ap_valid && ap_wr && q_hit(ap_addr)) begin
            queue[q_idx(ap_addr)] <=
                hwdata[asps_pkg::CHW+asps_pkg::GNW-1:0];
        end
    end

    // Software convert command pulse.
    assign sw_cmd = ap_valid && ap_wr && ap_addr == 9'(asps_pkg::OFS_CMD)
        && hwdata[asps_pkg::CMD_CONVERT];

    // Read data mux, registered ahead of the data phase.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (hready) begin
            hrdata <= 32'h0000_0000;
            if (hsel && !hwrite && htrans[1]) begin
                if (q_hit(haddr[8:0])) begin
                    hrdata <= 32'(queue[q_idx(haddr[8:0])]);
                end else if (reg_hit(haddr[8:0])) begin
                    unique case (haddr[7:0])
                        asps_pkg::OFS_CTRL: hrdata <= 32'(ctrl);
                        asps_pkg::OFS_PACER_DIV: hrdata <= pacer_div;
                        asps_pkg::OFS_BURST_DIV: hrdata <= burst_div;
                        asps_pkg::OFS_QLEN: hrdata <= 32'(qlen);
                        asps_pkg::OFS_STATUS: begin
                            hrdata <= {16'h0000, 2'h0, qptr, 6'h00,
                                state == asps_pkg::ASPS_BURST,
                                done_flag};
                        end
                        asps_pkg::OFS_RESULT: hrdata <= 32'(result);
                        default: hrdata <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // 5 MHz time base: 10 MHz crystal halved, made as an enable.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tb_cnt <= 5'h00;
            tb_tick <= 1'b0;
        end else begin
            tb_tick <= (tb_cnt == asps_pkg::TBASE_LAST);
            tb_cnt <= (tb_cnt == asps_pkg::TBASE_LAST) ? 5'h00
                : tb_cnt + 5'h01;
        end
    end

    // Internal pacer counter on the time base; one rate for all users.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pacer_cnt <= 32'h0000_0000;
            int_pulse <= 1'b0;
            pacer_tick <= 1'b0;
        end else begin
            int_pulse <= 1'b0;
            pacer_tick <= 1'b0;
            if (!ctrl.run) begin
                pacer_cnt <= 32'h0000_0000;
            end else if (tb_tick) begin
                if (div_end(pacer_cnt, pacer_div)) begin
                    pacer_cnt <= 32'h0000_0000;
                    int_pulse <= 1'b1;
                    pacer_tick <= 1'b1;
                end else begin
                    pacer_cnt <= pacer_cnt + 32'h0000_0001;
                end
            end
        end
    end

    // External pin edge detect with polarity select.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_q <= 1'b0;
        end else begin
            ext_q <= ext_pacer_clock_in;
        end
    end
    assign ext_edge = ctrl.fall ? (ext_q && !ext_pacer_clock_in)
        : (!ext_q && ext_pacer_clock_in);

    // Pacer pulse from the selected source.
    always_comb begin
        unique case (ctrl.src)
            asps_pkg::ASPS_SRC_INT: pace_pulse = int_pulse;
            asps_pkg::ASPS_SRC_EXT: pace_pulse = ext_edge && ctrl.run;
            default: pace_pulse = sw_cmd;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Burst clock, running only while a scan is in progress.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            burst_cnt <= 32'h0000_0000;
            burst_pulse <= 1'b0;
        end else begin
            burst_pulse <= 1'b0;
            if (state != asps_pkg::ASPS_BURST) begin
                burst_cnt <= 32'h0000_0000;
            end else if (tb_tick) begin
                if (div_end(burst_cnt, burst_div)) begin
                    burst_cnt <= 32'h0000_0000;
                    burst_pulse <= 1'b1;
                end else begin
                    burst_cnt <= burst_cnt + 32'h0000_0001;
                end
            end
        end
    end

    assign last_entry = (7'(qptr) + 7'h01) >= qlen;

    // Conversion launch: pacer in paced mode, burst clock in burst mode.
    assign entry_go = (state == asps_pkg::ASPS_IDLE)
        ? (pace_pulse && !ctrl.burst)
        : burst_pulse;

    // Scan state: a pacer pulse starts a burst, last entry ends it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= asps_pkg::ASPS_IDLE;
        end else begin
            unique case (state)
                asps_pkg::ASPS_IDLE: begin
                    if (pace_pulse && ctrl.burst) begin
                        state <= asps_pkg::ASPS_BURST;
                    end
                end
                asps_pkg::ASPS_BURST: begin
                    if (burst_pulse && last_entry) begin
                        state <= asps_pkg::ASPS_IDLE;
                    end
                end
                default: state <= asps_pkg::ASPS_IDLE;
            endcase
        end
    end

    // Queue pointer advance with wrap at the programmed length.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            qptr <= '0;
            conv_start <= 1'b0;
            conv_entry <= '0;
        end else begin
            conv_start <= entry_go;
            if (entry_go) begin
                conv_entry <= queue[qptr];
                qptr <= last_entry ? '0 : qptr + 1'b1;
            end
        end
    end

    // Done flag: set by converter, cleared by a new start; set wins.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_flag <= 1'b0;
            result <= '0;
        end else if (conv_done) begin
            done_flag <= 1'b1;
            result <= conv_data;
        end else if (entry_go) begin
            done_flag <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// *** sim/asps_seq_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
// Watches the sequencer ports for pulse shapes and start causes.
module asps_seq_chk (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Bus.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pacer and converter.
    input wire logic ext_pacer_clock_in,
    input wire logic conv_start,
    input wire asps_pkg::asps_entry_t conv_entry,
    input wire logic conv_done,
    input wire logic [asps_pkg::ADC_W-1:0] conv_data,
    input wire logic pacer_tick
);
    logic dp_wr;
    logic [7:0] dp_a;
    logic [4:0] ctrl;
    logic ext_q;
    logic act_edge;
    logic soft_cmd;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // Mirrors the control word from write data phases.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dp_wr <= 1'b0;
            dp_a <= 8'h00;
            ctrl <= 5'h00;
            ext_q <= 1'b0;
        end else begin
            dp_wr <= hsel && hready && htrans[1] && hwrite;
            dp_a <= haddr[7:0];
            ext_q <= ext_pacer_clock_in;
            if (dp_wr && dp_a == asps_pkg::OFS_CTRL) begin
                ctrl <= hwdata[4:0];
            end
        end
    end
    // Active pin edge in paced mode, and a software convert command.
    assign act_edge = ctrl[4] && !ctrl[0] && ctrl[2:1] == 2'h2
        && (ctrl[3] ? ext_q && !ext_pacer_clock_in
        : !ext_q && ext_pacer_clock_in);
    assign soft_cmd = dp_wr && dp_a == asps_pkg::OFS_CMD && hwdata[0]
        && ctrl[2:0] == 3'h0;
    ////////////////////////////////////////////////////////////////////////
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("Response was not OKAY.");
    a_ready_high: assert property (!$past(rst) |-> hreadyout)
        else $error("Slave inserted a wait state.");
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("Start lasted more than one cycle.");
    a_tick_pulse: assert property (pacer_tick |=> !pacer_tick)
        else $error("Pacer tick lasted more than one cycle.");
    a_tick_gap: assert property (pacer_tick |=> !pacer_tick [*8])
        else $error("Pacer ticks too close.");
    a_entry_hold: assert property ($changed(conv_entry) |-> conv_start)
        else $error("Entry changed without a start.");
    a_soft_start: assert property (soft_cmd |-> ##[1:2] conv_start)
        else $error("Convert command started nothing.");
    a_ext_start: assert property (act_edge |-> ##[1:4] conv_start)
        else $error("Active pin edge started nothing.");
endmodule
`default_nettype wire

// *** sim/asps_conv_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Converter: answers each start after LAT cycles with a result.
module asps_conv_model #(
    parameter int LAT = 3
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Converter side.
    input wire logic conv_start,
    input wire asps_pkg::asps_entry_t conv_entry,
    output logic conv_done,
    output logic [15:0] conv_data
);
    int cnt;
    logic [15:0] res;
    // Result is a tag byte over the entry; data outside done is the inverted result.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            conv_done <= 1'b0;
            res <= 16'h0000;
        end else begin
            conv_done <= cnt == 1;
            if (conv_start) begin
                cnt <= LAT;
                res <= {8'hA5, conv_entry};
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
    assign conv_data = conv_done ? res : ~res;
endmodule
`default_nettype wire

// *** sim/asps_seq_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module asps_seq_bench;
    logic clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic ext_pacer_clock_in, conv_start, conv_done, pacer_tick;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] conv_data;
    asps_pkg::asps_entry_t conv_entry;
    logic [7:0] seen[$];
    int t_st[$];
    int n_fail = 0, n_checks = 0, n_start = 0, n_tick = 0, i, k, j;
    assign hready = hreadyout;
    asps_seq asps_seq_inst (.clk(clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .ext_pacer_clock_in(ext_pacer_clock_in), .conv_start(conv_start),
        .conv_entry(conv_entry), .conv_done(conv_done),
        .conv_data(conv_data), .pacer_tick(pacer_tick));
    asps_conv_model asps_conv_model_inst (.clk(clk), .rst(rst),
        .conv_start(conv_start), .conv_entry(conv_entry),
        .conv_done(conv_done), .conv_data(conv_data));
    ////////////////////////////////////////////////////////////////////////
    // Clock of 10 ns.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Logs every start with its entry and cycle, and counts ticks.
    always @(posedge clk) begin
        if (conv_start === 1'b1) begin
            seen.push_back(conv_entry);
            t_st.push_back(int'($time / 10));
            n_start++;
        end
        if (pacer_tick === 1'b1) begin
            n_tick++;
        end
    end
    function automatic logic [7:0] ent(input int x);
        return 8'(8'h1D + x * 8'h25);
    endfunction
    task automatic results();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e,
        input string m);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    // Waits for hready under a bound.
    task automatic waitr();
        for (int n = 0; n < 50; n++) begin
            @(posedge clk);
            if (hready === 1'b1) return;
        end
        n_fail++;
        results();
    endtask
    // One single word transfer; read data lands in r.
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= asps_pkg::HTRANS_NONSEQ;
        waitr();
        htrans <= 2'h0;
        hwdata <= d;
        waitr();
        r = hrdata;
    endtask
    // Toggles the pacer pin n times, 30 cycles apart.
    task automatic pulse(input int n);
        for (int m = 0; m < n; m++) begin
            ext_pacer_clock_in <= ~ext_pacer_clock_in;
            repeat (30) @(posedge clk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        rst = 1'b1;
        {hsel, hwrite, ext_pacer_clock_in} = 3'h0;
        {haddr, hwdata, htrans} = 66'h0;
        hsize = 3'h2;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        bus(0, asps_pkg::OFS_CTRL, 0);
        chk(r, 32'h0, "ctrl rst");
        bus(0, 8'h40, 0);
        chk(r, 32'h0, "unmapped");
        for (i = 0; i < 4; i++) begin
            bus(1, asps_pkg::OFS_QBASE + 8'(4 * i), {24'h0, ent(i)});
        end
        bus(1, asps_pkg::OFS_QLEN, 32'h4);
        bus(0, asps_pkg::OFS_QLEN, 0);
        chk(r, 32'h4, "qlen");
        bus(1, asps_pkg::OFS_BURST_DIV, 32'h10);
        // Software conversions with polling.
        for (k = 0; k < 4; k++) begin
            bus(1, asps_pkg::OFS_CMD, 32'h1);
            for (i = 0; i < 20 && n_start <= k; i++) @(posedge clk);
            for (i = 0; i < 20; i++) begin
                bus(0, asps_pkg::OFS_STATUS, 0);
                if (r[0] === 1'b1) break;
            end
            chk(r[0], 1, "done");
            bus(0, asps_pkg::OFS_RESULT, 0);
            chk(r, {16'h0, 8'hA5, ent(k)}, "result");
        end
        // External pacer, rising then falling edges.
        bus(1, asps_pkg::OFS_CTRL, 32'h14);
        pulse(8);
        chk(n_start, 8, "rising");
        bus(1, asps_pkg::OFS_CTRL, 32'h1C);
        pulse(8);
        chk(n_start, 12, "falling");
        // One rising edge in burst mode scans the whole queue.
        bus(1, asps_pkg::OFS_CTRL, 32'h15);
        pulse(1);
        bus(0, asps_pkg::OFS_STATUS, 0);
        chk(r[1], 1, "busy");
        repeat (1500) @(posedge clk);
        chk(n_start, 16, "burst");
        chk(t_st[15] - t_st[14], 320, "burst gap");
        bus(0, asps_pkg::OFS_STATUS, 0);
        chk(r[1], 0, "idle");
        pulse(1);
        repeat (1000) @(posedge clk);
        chk(n_start, 16, "no burst");
        // Internal pacer in paced mode: one start per tick.
        bus(1, asps_pkg::OFS_PACER_DIV, 32'h10);
        bus(1, asps_pkg::OFS_CTRL, 32'h12);
        k = n_tick;
        i = n_start;
        repeat (1600) @(posedge clk);
        bus(1, asps_pkg::OFS_CTRL, 32'h2);
        repeat (5) @(posedge clk);
        j = n_tick - k;
        chk(j, 5, "tick count");
        chk(n_start - i, j, "paced int");
        for (i = 0; i < seen.size(); i++) begin
            chk(seen[i], ent(i % 4), "order");
        end
        results();
    end
endmodule
bind asps_seq asps_seq_chk asps_seq_chk_inst (.clk(clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .ext_pacer_clock_in(ext_pacer_clock_in), .conv_start(conv_start),
    .conv_entry(conv_entry), .conv_done(conv_done),
    .conv_data(conv_data), .pacer_tick(pacer_tick));
`default_nettype wire
